// ===== hw/rcia_pkg.sv
// Purpose: shared constants and types for the recovery counter and irq arbiter
// Assumes: 16-bit AXI4-Lite byte addresses, 32-bit data
// Notes:   vector codes count down from the top vector, two bytes per code
package rcia_pkg;
  // ************************************************************
  // counter and recovery
  // ************************************************************
  localparam int          CNT_W      = 12;
  localparam int          LIM_W      = 13;
  localparam logic [12:0] LONG_REC   = 13'h1000;
  localparam logic [12:0] SHORT_REC  = 13'h0020;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] OFF_FLAGS_LOW  = 16'hFE04;
  localparam logic [15:0] OFF_FLAGS_MID  = 16'hFE08;
  localparam logic [15:0] OFF_FLAGS_HIGH = 16'hFE0C;
  localparam logic [15:0] OFF_OPTION     = 16'hFE10;
  localparam logic [15:0] OFF_STATUS     = 16'hFE14;
  localparam int          LOW_LSB    = 2;
  localparam int          OPT_SHORT_RECOVERY_OPTION  = 0;
  localparam int          OPT_MON    = 1;
  localparam int          STAT_BUS   = 12;
  localparam int          STAT_LAT   = 13;
  localparam logic [1:0]  OPT_RST    = 2'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ************************************************************
  // vectors
  // ************************************************************
  localparam int          SRC_N      = 21;
  localparam int          CODE_W     = 5;
  localparam logic [15:0] VEC_TOP    = 16'hFFFE;
  localparam logic [15:0] VEC_MON    = 16'hFEFE;
  localparam logic [4:0]  CODE_RESET = 5'h00;
  localparam logic [4:0]  CODE_SWI   = 5'h01;
  localparam logic [4:0]  CODE_SRC0  = 5'h01;

  typedef enum logic [1:0] {
    RC_RUN  = 2'b00,
    RC_STOP = 2'b01,
    RC_WAKE = 2'b10
  } rcia_rec_e;

  typedef struct packed {
    logic        valid;
    logic [4:0]  code;
    logic [15:0] addr;
    logic        pc_minus1;
  } rcia_entry_s;
endpackage

// ===== hw/rcia_top.sv
// Purpose: recovery counter, watchdog prescale and interrupt arbitration
// Assumes: osc_tick marks one oscillator clock cycle in the aclk domain
// Notes:   the cpu does the actual stacking; this block steers it
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rcia_top #(
  parameter logic [12:0] LONG_LIM  = rcia_pkg::LONG_REC,
  parameter logic [12:0] SHORT_LIM = rcia_pkg::SHORT_REC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_tick,
  input  wire logic        power_on_reset_pulse,
  input  wire logic        internal_reset,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        stop_exec,
  input  wire logic        wake_irq,
  input  wire logic        wake_break,
  output logic             internal_bus_clocks_en,
  output logic             watchdog_clk_pulse,
  input  wire logic [21:1] irq_req,
  input  wire logic [21:1] irq_enable,
  input  wire logic        instr_done,
  input  wire logic        i_mask,
  input  wire logic        swi_exec,
  input  wire logic        rti_exec,
  input  wire logic        reset_vec_req,
  input  wire logic        service_done,
  output logic             entry_valid,
  output logic [4:0]       entry_code,
  output logic [15:0]      vector_hi_addr,
  output logic [15:0]      vector_lo_addr,
  output logic             push_pc_minus1,
  output logic             push_index_high,
  output logic             set_i_mask,
  output logic             restore_regs
);
  // ************************************************************
  // pin synchroniser
  // ************************************************************
  logic pin_meta_reg;
  logic pin_sync_reg;
  wire  ext_rst_act = ~pin_sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else if (clk_en) begin
      pin_meta_reg <= ext_reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ************************************************************
  // recovery counter
  // ************************************************************
  logic [rcia_pkg::CNT_W-1:0] cnt_reg;
  logic [rcia_pkg::CNT_W-1:0] cnt_next;
  logic [rcia_pkg::LIM_W-1:0] lim_reg;
  logic [rcia_pkg::LIM_W-1:0] lim_next;
  rcia_pkg::rcia_rec_e        st_reg;
  rcia_pkg::rcia_rec_e        st_next;
  logic                       wdog_reg;
  logic                       bus_en_reg;
  logic [1:0]                 opt_reg;

  wire tick      = clk_en & osc_tick;
  // the pin reset is absent here on purpose: the count survives it
  wire cnt_clear = internal_reset | power_on_reset_pulse | stop_exec;
  wire cnt_run   = tick & (st_reg != rcia_pkg::RC_STOP);
  wire cnt_full  = &cnt_reg;
  wire ovf       = cnt_run & cnt_full & ~cnt_clear;
  wire short_recovery_option     = opt_reg[rcia_pkg::OPT_SHORT_RECOVERY_OPTION];
  wire wake_ev   = wake_irq | wake_break | ext_rst_act | internal_reset;
  wire lim_hit   = cnt_run & ({1'b0, cnt_reg} == lim_reg - 13'h0001);

  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_clear) begin
      cnt_next = '0;
    end else if (cnt_run) begin
      cnt_next = cnt_reg + 12'h001;
    end
  end

  always_comb begin
    st_next  = st_reg;
    lim_next = lim_reg;
    case (st_reg)
      rcia_pkg::RC_RUN: begin
        if (stop_exec) begin
          st_next = rcia_pkg::RC_STOP;
        end
      end
      rcia_pkg::RC_STOP: begin
        if (wake_ev) begin
          st_next  = rcia_pkg::RC_WAKE;
          lim_next = short_recovery_option ? SHORT_LIM : LONG_LIM;
        end
      end
      rcia_pkg::RC_WAKE: begin
        if (lim_hit && !cnt_clear) begin
          st_next = rcia_pkg::RC_RUN;
        end
      end
      default: st_next = rcia_pkg::RC_RUN;
    endcase
    if (power_on_reset_pulse) begin
      st_next  = rcia_pkg::RC_WAKE;
      lim_next = LONG_LIM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg    <= '0;
      st_reg     <= rcia_pkg::RC_RUN;
      lim_reg    <= LONG_LIM;
      wdog_reg   <= 1'b0;
      bus_en_reg <= 1'b1;
    end else if (clk_en) begin
      cnt_reg    <= cnt_next;
      st_reg     <= st_next;
      lim_reg    <= lim_next;
      wdog_reg   <= ovf;
      bus_en_reg <= (st_next == rcia_pkg::RC_RUN);
    end
  end

  assign internal_bus_clocks_en = bus_en_reg;
  assign watchdog_clk_pulse     = wdog_reg;

  // ************************************************************
  // interrupt arbitration
  // ************************************************************
  rcia_pkg::rcia_entry_s ent_reg;
  rcia_pkg::rcia_entry_s ent_next;
  logic                  mask_q_reg;
  logic                  rti_reg;
  logic [21:1]           flag_reg;

  wire [21:1] pend     = irq_req & irq_enable;
  wire        any_pend = |pend;
  wire        boundary = clk_en & (instr_done | rti_exec);
  wire        mon      = opt_reg[rcia_pkg::OPT_MON];
  wire        unmasked = mask_q_reg & ~i_mask;
  wire        release_ev = service_done | unmasked;

  // lowest source number wins, since its vector sits highest
  function automatic logic [4:0] best_code(input logic [21:1] p);
    logic [4:0] c;
    c = '0;
    for (int i = rcia_pkg::SRC_N; i >= 1; i--) begin
      if (p[i]) begin
        c = rcia_pkg::CODE_SRC0 + 5'(i);
      end
    end
    return c;
  endfunction

  wire [4:0]  win_code = best_code(pend);
  wire [15:0] win_addr = rcia_pkg::VEC_TOP - {10'h000, win_code, 1'b0};
  wire [15:0] swi_addr = rcia_pkg::VEC_TOP - {10'h000, rcia_pkg::CODE_SWI, 1'b0};
  wire [15:0] rst_addr = mon ? rcia_pkg::VEC_MON : rcia_pkg::VEC_TOP;

  always_comb begin
    ent_next = ent_reg;
    if (ent_reg.valid && release_ev) begin
      ent_next.valid = 1'b0;
    end
    if (reset_vec_req) begin
      ent_next = '{1'b1, rcia_pkg::CODE_RESET, rst_addr, 1'b0};
    end else if (boundary && !ent_reg.valid) begin
      if (swi_exec) begin
        ent_next = '{1'b1, rcia_pkg::CODE_SWI, swi_addr, 1'b0};
      end else if (!i_mask && any_pend) begin
        ent_next = '{1'b1, win_code, win_addr, 1'b1};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ent_reg    <= '0;
      mask_q_reg <= 1'b1;
      rti_reg    <= 1'b0;
      flag_reg   <= '0;
    end else if (clk_en) begin
      ent_reg    <= ent_next;
      mask_q_reg <= i_mask;
      rti_reg    <= rti_exec;
      flag_reg   <= irq_req;
    end
  end

  assign entry_valid     = ent_reg.valid;
  assign entry_code      = ent_reg.code;
  assign vector_hi_addr  = ent_reg.addr;
  assign vector_lo_addr  = ent_reg.addr | 16'h0001;
  assign push_pc_minus1  = ent_reg.pc_minus1;
  assign push_index_high = 1'b0;
  assign set_i_mask      = ent_reg.valid;
  assign restore_regs    = rti_reg;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic        aw_have_reg;
  logic [15:0] aw_addr_reg;
  logic        w_have_reg;
  logic [31:0] w_data_reg;
  logic        w_strb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire wr_go   = clk_en & aw_have_reg & w_have_reg & ~bvalid_reg;

  wire [13:0] wa = aw_addr_reg[15:2];
  wire [13:0] ra = s_axi_araddr[15:2];
  wire w_opt  = (wa == rcia_pkg::OFF_OPTION[15:2]);
  wire w_ro   = (wa == rcia_pkg::OFF_FLAGS_LOW[15:2])
              | (wa == rcia_pkg::OFF_FLAGS_MID[15:2])
              | (wa == rcia_pkg::OFF_FLAGS_HIGH[15:2])
              | (wa == rcia_pkg::OFF_STATUS[15:2]);
  wire r_low  = (ra == rcia_pkg::OFF_FLAGS_LOW[15:2]);
  wire r_mid  = (ra == rcia_pkg::OFF_FLAGS_MID[15:2]);
  wire r_high = (ra == rcia_pkg::OFF_FLAGS_HIGH[15:2]);
  wire r_opt  = (ra == rcia_pkg::OFF_OPTION[15:2]);
  wire r_stat = (ra == rcia_pkg::OFF_STATUS[15:2]);
  wire r_hit  = r_low | r_mid | r_high | r_opt | r_stat;

  wire [31:0] low_val  = {24'h000000, flag_reg[6:1], 2'b00};
  wire [31:0] mid_val  = {24'h000000, flag_reg[14:7]};
  wire [31:0] high_val = {25'h0000000, flag_reg[21:15]};
  wire [31:0] opt_val  = {30'h00000000, opt_reg};
  wire [31:0] stat_val = {18'h00000, ent_reg.valid, bus_en_reg, cnt_reg};
  wire [31:0] rd_mux   = r_low  ? low_val  :
                         r_mid  ? mid_val  :
                         r_high ? high_val :
                         r_opt  ? opt_val  :
                         r_stat ? stat_val : 32'h00000000;

  assign s_axi_awready = clk_en & ~aw_have_reg & ~bvalid_reg;
  assign s_axi_wready  = clk_en & ~w_have_reg & ~bvalid_reg;
  assign s_axi_arready = clk_en & ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= rcia_pkg::RESP_OKAY;
      opt_reg     <= rcia_pkg::OPT_RST;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // flag registers ignore writes but still answer okay
        bresp_reg   <= (w_opt | w_ro) ? rcia_pkg::RESP_OKAY : rcia_pkg::RESP_SLVERR;
        if (w_opt && w_strb0_reg) begin
          opt_reg <= w_data_reg[1:0];
        end
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= rcia_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= r_hit ? rcia_pkg::RESP_OKAY : rcia_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_free_boundary;
    boundary && !ent_reg.valid && !reset_vec_req;
  endsequence

  sequence s_hw_request;
    s_free_boundary ##0 (!swi_exec && !i_mask && any_pend);
  endsequence

  chk_stop_clears: assert property (
    clk_en && stop_exec |=> cnt_reg == '0)
    else $error("stop did not clear the counter");

  chk_int_reset_clr: assert property (
    clk_en && internal_reset |=> cnt_reg == '0 && !watchdog_clk_pulse)
    else $error("internal reset did not clear the counter");

  chk_pin_keeps_cnt: assert property (
    clk_en && ext_rst_act && !cnt_clear && !tick |=> $stable(cnt_reg))
    else $error("pin reset disturbed the counter");

  chk_ovf_to_wdog: assert property (
    cnt_run && cnt_full && !cnt_clear |=> watchdog_clk_pulse && cnt_reg == '0)
    else $error("overflow gave no watchdog pulse");

  chk_wake_done: assert property (
    st_reg == rcia_pkg::RC_WAKE && lim_hit && !cnt_clear && !power_on_reset_pulse
    |=> internal_bus_clocks_en)
    else $error("bus clocks not enabled after recovery");

  chk_stop_gates: assert property (
    clk_en && st_reg == rcia_pkg::RC_RUN && stop_exec && !power_on_reset_pulse
    |=> !internal_bus_clocks_en ##0 st_reg == rcia_pkg::RC_STOP)
    else $error("bus clocks kept running in stop");

  chk_latch_hold: assert property (
    clk_en && ent_reg.valid && !release_ev && !reset_vec_req
    |=> ent_reg.valid && $stable(ent_reg.code))
    else $error("latched interrupt was displaced");

  chk_mask_blocks: assert property (
    s_free_boundary ##0 (i_mask && !swi_exec) |=> !entry_valid)
    else $error("masked interrupt was taken");

  chk_swi_taken: assert property (
    s_free_boundary ##0 swi_exec
    |=> entry_valid && entry_code == rcia_pkg::CODE_SWI && !push_pc_minus1)
    else $error("software interrupt not taken as required");

  chk_hw_priority: assert property (
    s_hw_request |=> entry_valid && push_pc_minus1
      && ((($past(pend) >> (entry_code - rcia_pkg::CODE_SRC0 - 5'h01)) & 21'h000001)
        == 21'h000001)
      && (($past(pend) & ((21'h000001 << (entry_code - rcia_pkg::CODE_SRC0 - 5'h01))
        - 21'h000001)) == 21'h000000))
    else $error("lower priority request won arbitration");

  chk_reset_vector: assert property (
    clk_en && reset_vec_req |=> entry_code == rcia_pkg::CODE_RESET
      && vector_hi_addr == $past(rst_addr))
    else $error("reset vector address wrong");
endmodule

// ===== verif/rcia_cpu_model.sv
// Purpose: cpu side that services one latched entry at a time and returns
// Assumes: service_done rises svc_lat+1 cycles after the entry is seen
// Notes:   the return pulse follows service so it acts as a new boundary
`timescale 1ns/1ps
module rcia_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       entry_valid,
  input  wire logic [4:0] entry_code,
  input  wire logic [3:0] svc_lat,
  output logic            service_done,
  output logic            rti_exec
);
  // ************************************************************
  // service loop
  // ************************************************************
  logic [4:0] log_q[$];
  logic [3:0] cnt_reg;
  logic       busy_reg;

  initial begin
    service_done = 1'b0;
    rti_exec = 1'b0;
  end

  // a latched entry is still high in the cycle after service, so it is not re-logged
  always @(posedge aclk) begin
    service_done <= 1'b0;
    rti_exec     <= service_done;
    if (!aresetn) begin
      busy_reg <= 1'b0;
    end else if (entry_valid && !busy_reg && !service_done) begin
      busy_reg <= 1'b1;
      cnt_reg  <= 4'h0;
      log_q.push_back(entry_code);
    end else if (busy_reg && cnt_reg == svc_lat) begin
      service_done <= 1'b1;
      busy_reg     <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// ===== verif/recovery_counter_irq_arbiter_tb.sv
// Purpose: self-checking bench for the recovery counter and irq arbiter
// Assumes: long and short recovery limits 64 and 8 replace 4096 and 32
// Notes:   request lines drop when their entry is serviced
`timescale 1ns/1ps
module recovery_counter_irq_arbiter_tb;
  logic        aclk, aresetn, clk_en, osc_tick, power_on_reset_pulse, internal_reset;
  logic [15:0] s_axi_awaddr, s_axi_araddr, vector_hi_addr, vector_lo_addr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, c0;
  logic [3:0]  s_axi_wstrb, svc_lat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        ext_reset_pin_n, stop_exec, wake_irq, wake_break, internal_bus_clocks_en;
  logic        watchdog_clk_pulse, instr_done, i_mask, swi_exec, rti_exec, reset_vec_req;
  logic        service_done, entry_valid, push_pc_minus1, push_index_high, set_i_mask;
  logic        restore_regs;
  logic [21:1] irq_req, irq_enable;
  logic [4:0]  entry_code;
  int          n_errors, n_compared, i, k, lim;

  rcia_top #(.LONG_LIM(13'h0040), .SHORT_LIM(13'h0008)) dut (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_tick, .power_on_reset_pulse, .internal_reset, .ext_reset_pin_n,
    .stop_exec, .wake_irq, .wake_break, .internal_bus_clocks_en, .watchdog_clk_pulse,
    .irq_req, .irq_enable, .instr_done, .i_mask, .swi_exec, .rti_exec, .reset_vec_req,
    .service_done, .entry_valid, .entry_code, .vector_hi_addr, .vector_lo_addr,
    .push_pc_minus1, .push_index_high, .set_i_mask, .restore_regs);
  rcia_cpu_model cpu (.aclk, .aresetn, .entry_valid, .entry_code, .svc_lat, .service_done,
    .rti_exec);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // a serviced source withdraws its request
  always @(posedge aclk) begin
    if (service_done && entry_code > 5'h01) irq_req[entry_code - 5'h01] <= 1'b0;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    chk(32'h0, 32'h1);
    print_verdict();
  endtask

  task automatic wait_bit(ref logic s, input logic lvl, input int lim_n);
    for (k = 0; k < lim_n; k++) begin
      @(posedge aclk);
      if (s === lvl) break;
    end
    if (k == lim_n) timed_out();
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] dd, output logic [1:0] rr);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    wait_bit(s_axi_arready, 1'b1, 50);
    s_axi_arvalid <= 1'b0;
    wait_bit(s_axi_rvalid, 1'b1, 50);
    dd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] dd, output logic [1:0] rr);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50 && !(aw_done && w_done); k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (k == 50) timed_out();
    wait_bit(s_axi_bvalid, 1'b1, 50);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic boundary();
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
  endtask

  task automatic chk_entry(input logic [4:0] code, input logic [15:0] top);
    logic [15:0] hi;
    hi = top - {10'h000, code, 1'b0};
    chk(entry_code, code);
    chk(vector_hi_addr, hi);
    chk(vector_lo_addr, hi | 16'h0001);
    chk(push_pc_minus1, code > 5'h01);
    chk({push_index_high, set_i_mask}, 2'b01);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {aresetn, osc_tick, power_on_reset_pulse, internal_reset, stop_exec} = 5'h00;
    {wake_irq, wake_break, instr_done, i_mask, swi_exec, reset_vec_req} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    clk_en = 1'b1;
    ext_reset_pin_n = 1'b1;
    s_axi_wstrb = 4'hF;
    svc_lat = 4'h3;
    irq_req = 21'h000000;
    irq_enable = 21'h1FFFFF;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(rcia_pkg::OFF_FLAGS_LOW, d, r);
    chk(d, 32'h0);
    irq_req <= 21'h15A5C3;
    repeat (2) @(posedge aclk);
    wr(rcia_pkg::OFF_FLAGS_LOW, 32'hFF, r);
    chk(r, rcia_pkg::RESP_OKAY);
    rd(rcia_pkg::OFF_FLAGS_LOW, d, r);
    chk(d, {24'h0, irq_req[6:1], 2'b00});
    rd(rcia_pkg::OFF_FLAGS_MID, d, r);
    chk(d, {24'h0, irq_req[14:7]});
    rd(rcia_pkg::OFF_FLAGS_HIGH, d, r);
    chk(d, {25'h0, irq_req[21:15]});
    rd(16'h0100, d, r);
    chk(r, rcia_pkg::RESP_SLVERR);
    irq_req <= 21'h000000;
    $display("test registers done");
    for (i = 1; i <= 21; i++) begin
      irq_req <= 21'h000001 << (i - 1);
      boundary();
      irq_req <= 21'h000000;
      wait_bit(entry_valid, 1'b1, 40);
      chk_entry(5'(i + 1), rcia_pkg::VEC_TOP);
      wait_bit(entry_valid, 1'b0, 40);
      @(posedge aclk);
      chk(restore_regs, 1'b1);
      @(posedge aclk);
    end
    $display("test vectors done");
    irq_enable <= 21'h1FFFFB;
    irq_req <= 21'h000004;
    boundary();
    repeat (4) @(posedge aclk);
    chk(entry_valid, 1'b0);
    irq_enable <= 21'h1FFFFF;
    i_mask <= 1'b1;
    boundary();
    repeat (4) @(posedge aclk);
    chk(entry_valid, 1'b0);
    swi_exec <= 1'b1;
    boundary();
    swi_exec <= 1'b0;
    wait_bit(entry_valid, 1'b1, 40);
    chk_entry(rcia_pkg::CODE_SWI, rcia_pkg::VEC_TOP);
    wait_bit(entry_valid, 1'b0, 40);
    i_mask <= 1'b0;
    irq_req <= 21'h000000;
    $display("test masking done");
    reset_vec_req <= 1'b1;
    irq_req <= 21'h000001;
    boundary();
    reset_vec_req <= 1'b0;
    wait_bit(entry_valid, 1'b1, 40);
    chk_entry(rcia_pkg::CODE_RESET, rcia_pkg::VEC_TOP);
    irq_req <= 21'h000000;
    wait_bit(entry_valid, 1'b0, 40);
    repeat (3) @(posedge aclk);
    wr(rcia_pkg::OFF_OPTION, 32'h2, r);
    reset_vec_req <= 1'b1;
    @(posedge aclk);
    reset_vec_req <= 1'b0;
    wait_bit(entry_valid, 1'b1, 40);
    chk_entry(rcia_pkg::CODE_RESET, rcia_pkg::VEC_MON);
    wait_bit(entry_valid, 1'b0, 40);
    repeat (3) @(posedge aclk);
    $display("test reset entry done");
    cpu.log_q.delete();
    svc_lat <= 4'h6;
    irq_req <= 21'h000014;
    boundary();
    wait_bit(entry_valid, 1'b1, 40);
    irq_req[1] <= 1'b1;
    boundary();
    @(posedge aclk);
    chk(entry_code, 5'h04);
    for (i = 0; i < 100 && cpu.log_q.size() < 3; i++) @(posedge aclk);
    if (i == 100) timed_out();
    chk({cpu.log_q[0], cpu.log_q[1], cpu.log_q[2]}, {5'h04, 5'h02, 5'h06});
    $display("test latching done");
    osc_tick <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(rcia_pkg::OFF_OPTION, (i == 0) ? 32'h1 : 32'h0, r);
      if (i < 2) begin
        stop_exec <= 1'b1;
        @(posedge aclk);
        stop_exec <= 1'b0;
        rd(rcia_pkg::OFF_STATUS, d, r);
        chk(d[12:0], 13'h0000);
      end
      if (i == 0) wake_irq <= 1'b1;
      else if (i == 1) wake_break <= 1'b1;
      else power_on_reset_pulse <= 1'b1;
      @(posedge aclk);
      {wake_irq, wake_break, power_on_reset_pulse} <= 3'h0;
      wait_bit(internal_bus_clocks_en, 1'b1, 200);
      lim = (i == 0) ? 8 : 64;
      chk(k >= lim - 1 && k <= lim + 1, 1'b1);
    end
    $display("test recovery done");
    wait_bit(watchdog_clk_pulse, 1'b1, 5000);
    wait_bit(watchdog_clk_pulse, 1'b1, 5000);
    chk(k, 4095);
    osc_tick <= 1'b0;
    @(posedge aclk);
    rd(rcia_pkg::OFF_STATUS, c0, r);
    ext_reset_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_reset_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(rcia_pkg::OFF_STATUS, d, r);
    chk(d[11:0], c0[11:0]);
    internal_reset <= 1'b1;
    @(posedge aclk);
    internal_reset <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(rcia_pkg::OFF_STATUS, d, r);
    chk(d[11:0], 12'h000);
    $display("test counter resets done");
    print_verdict();
  end
endmodule
